// ### hw/fault_blink_map.vh
// Register map, field positions, rated-current limits, fault codes and timing figures of the fault indicator
`ifndef FAULT_BLINK_MAP_VH
`define FAULT_BLINK_MAP_VH

`define CLK_HZ 20000000
`define CYC_PER_MS (`CLK_HZ / 1000)

`define FLICKER_MS 2000
`define FLICK_HALF_MS 50
`define PAUSE_MS 1000
`define BLINK_HALF_MS 500
`define WDOG_MS 100

`define OFF_CTRL 8'h00
`define OFF_RATED_ONE 8'h04
`define OFF_RATED_TWO 8'h08
`define OFF_RATED_THREE 8'h0C
`define OFF_STATUS 8'h10
`define OFF_IRQ_STAT 8'h14
`define OFF_IRQ_MASK 8'h18

`define CTRL_SINGLE_PHASE 0
`define CTRL_SOFT_RESET 1

`define EV_CFG 0
`define EV_ADC 1
`define EV_HALL 2
`define EV_BUS 3
`define EV_W 4

`define RATED_MIN 8'h09
`define SEL_MAX 8'h63
`define RATED_MAX 8'h96

`define CODE_CFG 4'h1
`define CODE_ADC 4'h2
`define CODE_HALL 4'h3

`endif

// ### hw/fault_blink_code_indicator.v
// Fault blink-code indicator with parameter commit, bus watchdog and APB registers
`include "fault_blink_map.vh"

module fault_blink_code_indicator #(
    parameter NUM_ADC = 3,
    parameter NUM_HALL = 3,
    parameter [31:0] FLICKER_CYC = `FLICKER_MS * `CYC_PER_MS,
    parameter [31:0] FLICK_HALF_CYC = `FLICK_HALF_MS * `CYC_PER_MS,
    parameter [31:0] PAUSE_CYC = `PAUSE_MS * `CYC_PER_MS,
    parameter [31:0] BLINK_HALF_CYC = `BLINK_HALF_MS * `CYC_PER_MS,
    parameter [31:0] WDOG_CYC = `WDOG_MS * `CYC_PER_MS
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [3:0] sel_amps,
    input wire [3:0] sel_tenths,
    input wire [NUM_ADC-1:0] adc_fail,
    input wire [NUM_HALL-1:0] hall_fail,
    input wire bus_activity,
    output reg [7:0] rated_current_phase_one,
    output reg [7:0] rated_current_phase_two,
    output reg [7:0] rated_current_phase_three,
    output reg stop_led,
    output reg run_led,
    output reg bus_lost,
    output reg irq
);

    localparam ST_IDLE = 3'h0;
    localparam ST_FLICK = 3'h1;
    localparam ST_PAUSE1 = 3'h2;
    localparam ST_CODE = 3'h3;
    localparam ST_PAUSE2 = 3'h4;
    localparam ST_ARG = 3'h5;
    localparam ST_PAUSE3 = 3'h6;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam SYNC_W = 9 + NUM_ADC + NUM_HALL;
    reg [SYNC_W-1:0] sync1_q, sync2_q;
    reg bus_s3_q;
    wire [7:0] sel_s2_q = sync2_q[7:0];
    wire [NUM_ADC-1:0] adc_s2_q = sync2_q[8 +: NUM_ADC];
    wire [NUM_HALL-1:0] hall_s2_q = sync2_q[8 + NUM_ADC +: NUM_HALL];
    wire bus_s2_q = sync2_q[SYNC_W-1];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= {SYNC_W{1'b0}};
            sync2_q <= {SYNC_W{1'b0}};
            bus_s3_q <= 1'b0;
        end else begin
            sync1_q <= {bus_activity, hall_fail, adc_fail, sel_amps, sel_tenths};
            sync2_q <= sync1_q;
            bus_s3_q <= bus_s2_q;
        end
    end

    // ------------------------------------------------------------
    // Selector value and register set
    // ------------------------------------------------------------
    wire [7:0] sel_amps_w = {4'h0, sel_s2_q[7:4]};
    wire [7:0] sel_val = sel_amps_w * 8'h0A + {4'h0, sel_s2_q[3:0]};
    wire sel_zero = (sel_s2_q == 8'h00);
    wire sel_ok = (sel_s2_q[3:0] <= 4'h9) && (sel_val >= `RATED_MIN) && (sel_val <= `SEL_MAX);
    reg single_phase_q;
    reg [7:0] rated_one_q, rated_two_q, rated_three_q;
    reg [`EV_W-1:0] stat_q, mask_q, ev_prev_q;
    reg [1:0] boot_q;
    reg soft_reset_q;
    reg sel_used_q, sel_bad_q;
    reg [3:0] code_q, arg_q;
    wire acc = psel && penable && pready;
    wire wr = acc && pwrite;
    wire [7:0] wval = pwdata[7:0];
    wire wval_ok = (wval == 8'h00) || ((wval >= `RATED_MIN) && (wval <= `RATED_MAX));
    wire rated_addr = (paddr == `OFF_RATED_ONE) || (paddr == `OFF_RATED_TWO)
                      || (paddr == `OFF_RATED_THREE);
    wire bad_wval = pwrite && rated_addr && !wval_ok;
    wire mapped = rated_addr || (paddr == `OFF_CTRL) || (paddr == `OFF_STATUS)
                  || (paddr == `OFF_IRQ_STAT) || (paddr == `OFF_IRQ_MASK);

    // ------------------------------------------------------------
    // Fault detection and priority
    // ------------------------------------------------------------
    reg [3:0] adc_idx, hall_idx;
    integer i;
    always @* begin
        adc_idx = 4'h0;
        hall_idx = 4'h0;
        for (i = NUM_ADC - 1; i >= 0; i = i - 1) begin
            if (adc_s2_q[i]) begin
                adc_idx = i[3:0] + 4'h1;
            end
        end
        for (i = NUM_HALL - 1; i >= 0; i = i - 1) begin
            if (hall_s2_q[i]) begin
                hall_idx = i[3:0] + 4'h1;
            end
        end
    end
    // missing rated current or invalid selector value, only judged after the boot commit
    wire cfg_fault = (boot_q == 2'h3) && (single_phase_q ?
        ((rated_current_phase_one == 8'h00) || (rated_current_phase_two == 8'h00)
         || (rated_current_phase_three == 8'h00)) :
        ((sel_used_q && sel_bad_q) || (!sel_used_q && rated_current_phase_one == 8'h00)));
    wire adc_fault = |adc_s2_q;
    wire hall_fault = |hall_s2_q;
    wire any_fault = cfg_fault || adc_fault || hall_fault;
    wire [3:0] next_code = cfg_fault ? `CODE_CFG
                           : (adc_fault ? `CODE_ADC : (hall_fault ? `CODE_HALL : 4'h0));
    wire [3:0] next_arg = cfg_fault ? 4'h0 : (adc_fault ? adc_idx : hall_idx);

    // ------------------------------------------------------------
    // Parameter commit and APB registers
    // ------------------------------------------------------------
    // commit at boot or soft reset
    wire commit = (boot_q == 2'h2) || soft_reset_q;
    wire [`EV_W-1:0] ev_now = {bus_lost, hall_fault, adc_fault, cfg_fault};
    wire [`EV_W-1:0] ev_rise = ev_now & ~ev_prev_q;
    wire [`EV_W-1:0] stat_clr = (wr && paddr == `OFF_IRQ_STAT) ? pwdata[`EV_W-1:0] : {`EV_W{1'b0}};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_q <= 2'h0;
            soft_reset_q <= 1'b0;
            single_phase_q <= 1'b0;
            rated_one_q <= 8'h00;
            rated_two_q <= 8'h00;
            rated_three_q <= 8'h00;
            mask_q <= {`EV_W{1'b0}};
            stat_q <= {`EV_W{1'b0}};
            ev_prev_q <= {`EV_W{1'b0}};
            rated_current_phase_one <= 8'h00;
            rated_current_phase_two <= 8'h00;
            rated_current_phase_three <= 8'h00;
            sel_used_q <= 1'b0;
            sel_bad_q <= 1'b0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            irq <= 1'b0;
        end else begin
            if (boot_q != 2'h3) begin
                boot_q <= boot_q + 2'h1;
            end
            soft_reset_q <= wr && (paddr == `OFF_CTRL) && pwdata[`CTRL_SOFT_RESET];
            ev_prev_q <= ev_now;
            // Set wins over write-one-to-clear
            stat_q <= (stat_q & ~stat_clr) | ev_rise;
            irq <= |(stat_q & mask_q);
            if (commit) begin
                sel_used_q <= !sel_zero;
                sel_bad_q <= !sel_ok;
                rated_current_phase_one <= sel_zero ? rated_one_q : sel_val;
                rated_current_phase_two <= sel_zero ? rated_two_q : sel_val;
                rated_current_phase_three <= sel_zero ? rated_three_q : sel_val;
            end
            pready <= psel && penable && !pready;
            if (psel && penable && !pready) begin
                pslverr <= !mapped || bad_wval;
                prdata <= 32'h00000000;
                if (!pwrite) begin
                    if (paddr == `OFF_CTRL) begin
                        prdata[`CTRL_SINGLE_PHASE] <= single_phase_q;
                    end else if (paddr == `OFF_RATED_ONE) begin
                        prdata[7:0] <= rated_one_q;
                    end else if (paddr == `OFF_RATED_TWO) begin
                        prdata[7:0] <= rated_two_q;
                    end else if (paddr == `OFF_RATED_THREE) begin
                        prdata[7:0] <= rated_three_q;
                    end else if (paddr == `OFF_STATUS) begin
                        prdata <= {8'h00, sel_val, 5'h00, bus_lost, any_fault, cfg_fault,
                                   arg_q, code_q};
                    end else if (paddr == `OFF_IRQ_STAT) begin
                        prdata[`EV_W-1:0] <= stat_q;
                    end else if (paddr == `OFF_IRQ_MASK) begin
                        prdata[`EV_W-1:0] <= mask_q;
                    end
                end
            end
            if (wr && !pslverr) begin
                if (paddr == `OFF_CTRL) begin
                    single_phase_q <= pwdata[`CTRL_SINGLE_PHASE];
                end else if (paddr == `OFF_RATED_ONE) begin
                    rated_one_q <= wval;
                end else if (paddr == `OFF_RATED_TWO) begin
                    rated_two_q <= wval;
                end else if (paddr == `OFF_RATED_THREE) begin
                    rated_three_q <= wval;
                end else if (paddr == `OFF_IRQ_MASK) begin
                    mask_q <= pwdata[`EV_W-1:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Terminal bus watchdog
    // ------------------------------------------------------------
    reg [31:0] wdog_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_q <= 32'h00000000;
            bus_lost <= 1'b0;
            run_led <= 1'b0;
        end else begin
            if (bus_s2_q != bus_s3_q) begin
                wdog_q <= 32'h00000000;
                bus_lost <= 1'b0;
                run_led <= 1'b1;
            end else if (wdog_q >= WDOG_CYC - 32'h1) begin
                bus_lost <= 1'b1;
                run_led <= 1'b0;
            end else begin
                wdog_q <= wdog_q + 32'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Blink sequencer
    // ------------------------------------------------------------
    reg [2:0] state_q;
    reg [31:0] timer_q, half_q;
    reg [3:0] blinks_q;
    reg phase_q;
    wire tdone = (timer_q == 32'h00000000);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            timer_q <= 32'h00000000;
            half_q <= 32'h00000000;
            blinks_q <= 4'h0;
            phase_q <= 1'b0;
            code_q <= 4'h0;
            arg_q <= 4'h0;
            stop_led <= 1'b0;
        end else begin
            if (!tdone) begin
                timer_q <= timer_q - 32'h1;
            end
            if (!any_fault) begin
                state_q <= ST_IDLE;
                stop_led <= bus_lost;
                code_q <= 4'h0;
                arg_q <= 4'h0;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        code_q <= next_code;
                        arg_q <= next_arg;
                        state_q <= ST_FLICK;
                        timer_q <= FLICKER_CYC - 32'h1;
                        half_q <= FLICK_HALF_CYC - 32'h1;
                        stop_led <= 1'b1;
                    end
                    ST_FLICK: begin
                        if (half_q == 32'h00000000) begin
                            half_q <= FLICK_HALF_CYC - 32'h1;
                            stop_led <= !stop_led;
                        end else begin
                            half_q <= half_q - 32'h1;
                        end
                        if (tdone) begin
                            state_q <= ST_PAUSE1;
                            timer_q <= PAUSE_CYC - 32'h1;
                            stop_led <= 1'b0;
                        end
                    end
                    ST_PAUSE1, ST_PAUSE2: begin
                        if (tdone) begin
                            state_q <= (state_q == ST_PAUSE1) ? ST_CODE : ST_ARG;
                            blinks_q <= (state_q == ST_PAUSE1) ? code_q : arg_q;
                            timer_q <= BLINK_HALF_CYC - 32'h1;
                            phase_q <= 1'b1;
                            stop_led <= (state_q == ST_PAUSE1) || (arg_q != 4'h0);
                            if (state_q == ST_PAUSE2 && arg_q == 4'h0) begin
                                state_q <= ST_PAUSE3;
                                timer_q <= PAUSE_CYC - 32'h1;
                            end
                        end
                    end
                    ST_CODE, ST_ARG: begin
                        if (tdone) begin
                            timer_q <= BLINK_HALF_CYC - 32'h1;
                            phase_q <= !phase_q;
                            stop_led <= !phase_q;
                            if (!phase_q) begin
                                blinks_q <= blinks_q - 4'h1;
                                if (blinks_q == 4'h1) begin
                                    state_q <= (state_q == ST_CODE) ? ST_PAUSE2 : ST_PAUSE3;
                                    timer_q <= PAUSE_CYC - 32'h1;
                                    stop_led <= 1'b0;
                                end
                            end
                        end
                    end
                    default: begin
                        stop_led <= 1'b0;
                        if (tdone) begin
                            state_q <= ST_IDLE;
                        end
                    end
                endcase
            end
        end
    end

endmodule

// ### test/fault_blink_props.sv
// Port-level assertions for the fault blink-code indicator
module fault_blink_props #(
    parameter [31:0] WDOG_CYC = 50
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic bus_activity,
    input wire logic [7:0] rated_current_phase_one,
    input wire logic [7:0] rated_current_phase_two,
    input wire logic [7:0] rated_current_phase_three,
    input wire logic run_led,
    input wire logic bus_lost
);
    logic [7:0] quiet_q;
    logic [3:0] since_q;
    logic act_q;
    logic done_w;
    logic soft_w;
    assign done_w = psel && penable && pready;
    assign soft_w = done_w && pwrite && paddr == 8'h00 && pwdata[1];
    // ----------------------------------------
    // Quiet-time and commit-age counters
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet_q <= 8'h00;
            since_q <= 4'h0;
            act_q <= 1'b0;
        end else begin
            act_q <= bus_activity;
            quiet_q <= (bus_activity != act_q) ? 8'h00 : quiet_q + {7'h00, quiet_q != 8'hFF};
            since_q <= soft_w ? 4'h0 : since_q + {3'h0, since_q != 4'hF};
        end
    end
    function automatic logic ok_r(logic [7:0] v);
        return v == 8'h00 || (v >= 8'h09 && v <= 8'h96);
    endfunction
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_ready_resp;
        psel && penable && !pready |=> pready;
    endproperty
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    property p_ready_qual;
        pready |-> psel && penable;
    endproperty
    property p_unmapped;
        done_w && paddr > 8'h18 |-> pslverr && (pwrite || prdata == 32'h0);
    endproperty
    property p_bad_rated;
        done_w && pwrite && paddr inside {8'h04, 8'h08, 8'h0C} && pwdata > 32'h96 |-> pslverr;
    endproperty
    property p_rated_range;
        ok_r(rated_current_phase_one) && ok_r(rated_current_phase_two)
            && ok_r(rated_current_phase_three);
    endproperty
    property p_commit;
        !$stable({rated_current_phase_one, rated_current_phase_two, rated_current_phase_three})
            |-> since_q <= 4'h6;
    endproperty
    property p_lost_late;
        $rose(bus_lost) |-> quiet_q >= WDOG_CYC;
    endproperty
    property p_lost_due;
        quiet_q >= WDOG_CYC + 8 |-> bus_lost;
    endproperty
    property p_run_off;
        bus_lost |-> !run_led;
    endproperty
    a_ready_resp: assert property (p_ready_resp) else $error("pready missing");
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
    a_ready_qual: assert property (p_ready_qual) else $error("pready unasked");
    a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
    a_bad_rated: assert property (p_bad_rated) else $error("bad rated accepted");
    a_rated_range: assert property (p_rated_range) else $error("rated out of range");
    a_commit: assert property (p_commit) else $error("rated changed without commit");
    a_lost_late: assert property (p_lost_late) else $error("bus lost too early");
    a_lost_due: assert property (p_lost_due) else $error("bus lost missing");
    a_run_off: assert property (p_run_off) else $error("run led on while lost");
    c_lost: cover property ($rose(bus_lost));
    c_err: cover property (pready && pslverr);
    c_commit: cover property (!$stable(rated_current_phase_one));
endmodule

bind fault_blink_code_indicator fault_blink_props #(.WDOG_CYC(WDOG_CYC)) fault_blink_props_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_activity(bus_activity), .rated_current_phase_one(rated_current_phase_one),
    .rated_current_phase_two(rated_current_phase_two),
    .rated_current_phase_three(rated_current_phase_three), .run_led(run_led),
    .bus_lost(bus_lost));

// ### test/fault_far_side.sv
// Converters, current sensors and terminal bus traffic seen by the indicator
module fault_far_side (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic traffic_on,
    input wire logic slow,
    input wire logic [2:0] adc_err,
    input wire logic [2:0] hall_err,
    output logic bus_activity,
    output logic [2:0] adc_fail,
    output logic [2:0] hall_fail
);
    logic [5:0] gap_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= 6'h00;
            bus_activity <= 1'b0;
            adc_fail <= 3'h0;
            hall_fail <= 3'h0;
        end else begin
            adc_fail <= adc_err;
            hall_fail <= hall_err;
            if (traffic_on && gap_q >= (slow ? 6'h27 : 6'h01)) begin
                gap_q <= 6'h00;
                bus_activity <= ~bus_activity;
            end else begin
                gap_q <= gap_q + 6'h01;
            end
        end
    end
endmodule

// ### test/tb_fault_blink_code_indicator.sv
// Self-checking bench for the fault blink-code indicator
`include "fault_blink_map.vh"
`define CHK(nm, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        n_fail++; \
        $display("Error %s expected %0h seen %0h", nm, e, g); \
    end \
end
module tb_fault_blink_code_indicator;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PAUSE_C = 20;
    localparam int BLINK_C = 5;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] sel_amps = 4'h3, sel_tenths = 4'h5;
    logic traffic_on = 1'b1, slow = 1'b0;
    logic [2:0] adc_err = 3'h0, hall_err = 3'h0, adc_fail, hall_fail;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, bus_activity, stop_led, run_led, bus_lost, irq;
    logic [7:0] r1, r2, r3;
    int n_fail = 0, num_checks = 0, cyc = 0;
    always #25 pclk = ~pclk;
    fault_blink_code_indicator #(.FLICKER_CYC(40), .FLICK_HALF_CYC(4), .PAUSE_CYC(PAUSE_C),
        .BLINK_HALF_CYC(BLINK_C), .WDOG_CYC(50)) fault_blink_code_indicator_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sel_amps(sel_amps), .sel_tenths(sel_tenths), .adc_fail(adc_fail),
        .hall_fail(hall_fail), .bus_activity(bus_activity), .rated_current_phase_one(r1),
        .rated_current_phase_two(r2), .rated_current_phase_three(r3), .stop_led(stop_led),
        .run_led(run_led), .bus_lost(bus_lost), .irq(irq));
    fault_far_side fault_far_side_inst (.pclk(pclk), .presetn(presetn),
        .traffic_on(traffic_on), .slow(slow), .adc_err(adc_err), .hall_err(hall_err),
        .bus_activity(bus_activity), .adc_fail(adc_fail), .hall_fail(hall_fail));
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
            n_fail++;
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic watch_seq(input int code, input int arg);
        int n = 0, run = 1, low = 0, g = 0, flk = 0, c1 = 0, c2 = 0;
        logic prev = 1'b1, done = 1'b0;
        while (stop_led !== 1'b1 && n < 200) begin
            @(negedge pclk);
            n++;
        end
        for (int k = 0; k < 600 && !done; k++) begin
            @(negedge pclk);
            if (stop_led === 1'b1) begin
                if (!prev && low >= PAUSE_C)
                    g++;
                run++;
                low = 0;
            end else begin
                if (prev && run < BLINK_C && g > 0)
                    done = 1'b1;
                else if (prev && run < BLINK_C)
                    flk++;
                else if (prev && run == BLINK_C && g == 1)
                    c1++;
                else if (prev && run == BLINK_C)
                    c2++;
                run = 0;
                low++;
            end
            prev = stop_led;
        end
        `CHK("flicker", 5, flk);
        `CHK("code", code, c1);
        `CHK("arg", arg, c2);
        `CHK("restart", 1'b1, done);
    endtask
    task automatic t_boot;
        settle(10);
        `CHK("rated", 24'h232323, {r1, r2, r3});
        `CHK("run_led", 1'b1, run_led);
        `CHK("stop_led", 1'b0, stop_led);
    endtask
    task automatic t_commit;
        @(posedge pclk);
        sel_amps <= 4'h9;
        sel_tenths <= 4'h9;
        settle(10);
        `CHK("rated held", 8'h23, r1);
        apb(1'b1, `OFF_CTRL, 32'h2);
        settle(4);
        `CHK("rated sel", 24'h636363, {r1, r2, r3});
        apb(1'b1, `OFF_RATED_ONE, 32'h96);
        `CHK("err one", 1'b0, err);
        apb(1'b1, `OFF_RATED_TWO, 32'h97);
        `CHK("err two", 1'b1, err);
        apb(1'b1, `OFF_RATED_THREE, 32'h9);
        apb(1'b0, `OFF_RATED_TWO, 32'h0);
        `CHK("two kept", 32'h0, rd);
        apb(1'b0, 8'h1C, 32'h0);
        `CHK("unmapped", 33'h100000000, {err, rd});
        `CHK("rated idle", 8'h63, r1);
        @(posedge pclk);
        sel_amps <= 4'h0;
        sel_tenths <= 4'h0;
        settle(4);
        apb(1'b1, `OFF_CTRL, 32'h2);
        settle(4);
        `CHK("rated regs", 24'h960009, {r1, r2, r3});
        settle(10);
        `CHK("stop_led", 1'b0, stop_led);
    endtask
    task automatic t_cfg;
        apb(1'b1, `OFF_CTRL, 32'h1);
        watch_seq(1, 0);
        apb(1'b1, `OFF_RATED_TWO, 32'hA);
        apb(1'b1, `OFF_CTRL, 32'h3);
        settle(6);
        `CHK("stop_led", 1'b0, stop_led);
        apb(1'b1, `OFF_RATED_ONE, 32'h0);
        apb(1'b1, `OFF_CTRL, 32'h2);
        watch_seq(1, 0);
        apb(1'b1, `OFF_RATED_ONE, 32'hF);
        apb(1'b1, `OFF_CTRL, 32'h2);
        settle(6);
        `CHK("rated", 24'h0F0A09, {r1, r2, r3});
        `CHK("stop_led", 1'b0, stop_led);
    endtask
    task automatic t_sens;
        @(posedge pclk);
        adc_err <= 3'b100;
        hall_err <= 3'b010;
        watch_seq(2, 3);
        @(posedge pclk);
        adc_err <= 3'h0;
        hall_err <= 3'h0;
        settle(8);
        `CHK("stop_led", 1'b0, stop_led);
        @(posedge pclk);
        hall_err <= 3'b001;
        watch_seq(3, 1);
        apb(1'b0, `OFF_STATUS, 32'h0);
        `CHK("status", 32'h00000213, rd);
        @(posedge pclk);
        hall_err <= 3'h0;
    endtask
    task automatic t_wdog;
        apb(1'b1, `OFF_IRQ_MASK, 32'h8);
        @(posedge pclk);
        slow <= 1'b1;
        settle(200);
        `CHK("slow bus", 1'b0, bus_lost);
        @(posedge pclk);
        traffic_on <= 1'b0;
        for (int k = 0; k < 120 && bus_lost !== 1'b1; k++)
            @(negedge pclk);
        @(negedge pclk);
        `CHK("leds lost", 3'b101, {bus_lost, run_led, stop_led});
        settle(3);
        `CHK("irq", 1'b1, irq);
        apb(1'b0, `OFF_IRQ_STAT, 32'h0);
        `CHK("irq_stat", 4'hF, rd[3:0]);
        apb(1'b1, `OFF_IRQ_MASK, 32'h0);
        settle(2);
        `CHK("irq masked", 1'b0, irq);
        apb(1'b1, `OFF_IRQ_STAT, 32'hF);
        apb(1'b0, `OFF_IRQ_STAT, 32'h0);
        `CHK("irq_stat clr", 4'h0, rd[3:0]);
        @(posedge pclk);
        traffic_on <= 1'b1;
        slow <= 1'b0;
        settle(12);
        `CHK("bus back", 2'b01, {bus_lost, run_led});
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_boot();
        t_commit();
        t_cfg();
        t_sens();
        t_wdog();
        tally_and_finish();
    end
endmodule
